// >>> src/cbt_pkg.sv
// Constants and types for the CAN bit-timing and mailbox-direction block
//
// Overview of operation
// - Jump width field codes one to four quanta
// - Prescaler code n gives 2(n+1) clocks per quantum
// - Sample mode 0: one sample, end of segment one
// - Sample mode 1: three samples around that point
// - Segment two code n gives n+1 quanta
// - Segment one code n gives n+1 quanta
// - Direction bit 0 transmit, 1 receive
// - Bits 15..9 mailboxes 7..1, 7..0 mailboxes 15..8
// - Direction bit 8 reads one, ignores writes
package cbt_pkg;
  // Byte addresses on the register bus
  localparam logic [7:0] CBT_BIT_TIMING_ADDR = 8'h00;
  localparam logic [7:0] CBT_MAILBOX_DIR_ADDR = 8'h04;
  // Reset values
  localparam logic [15:0] CBT_BIT_TIMING_RST = 16'h0000;
  localparam logic [15:0] CBT_MAILBOX_DIR_RST = 16'h0100;
  // Field positions in the timing register, and the reserved direction bit
  localparam int CBT_SJW_LSB = 14;
  localparam int CBT_PRESC_LSB = 8;
  localparam int CBT_SMODE_BIT = 7;
  localparam int CBT_SEG2_LSB = 4;
  localparam int CBT_SEG1_LSB = 0;
  localparam int CBT_DIR_RSVD_BIT = 8;
  // AXI response codes
  localparam logic [1:0] CBT_RESP_OKAY = 2'b00;
  localparam logic [1:0] CBT_RESP_SLVERR = 2'b10;

  // Decoded timing, in quanta and clocks
  typedef struct packed {
    logic [2:0] sjw_tq;
    logic [7:0] tq_clocks;
    logic       triple;
    logic [3:0] seg2_tq;
    logic [4:0] seg1_tq;
  } cbt_timing_t;

  // Quantum phase within a nominal bit
  typedef enum logic [1:0] {CBT_SYNC, CBT_SEG1, CBT_SEG2} cbt_phase_t;
endpackage

// >>> src/cbt_regs.sv
// Register file and bit-time sequencer for the CAN timing block
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module cbt_regs
  import cbt_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receive line from the transceiver
  input  wire logic        can_rx,
  // Settings, sample results and bit start toward the protocol engine
  output var  logic [15:1] mailbox_rx_dir,
  output var  cbt_timing_t timing,
  output var  logic        sample_strobe,
  output var  logic        sampled_bit,
  output var  logic        bit_start
);

  ////////////////////////////////////////////////////////////////////
  // Register storage
  logic [15:0] bit_timing_config;
  logic [14:0] dir_bits; // 15..9 and 7..0, reserved bit dropped
  wire  [15:0] mailbox_direction_config =
    {dir_bits[14:8], 1'b1, dir_bits[7:0]};

  // Write channel: address and data taken in either order
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_held && w_held && !s_axi_bvalid;
  wire wr_tim  = aw_addr == CBT_BIT_TIMING_ADDR;
  wire wr_dir  = aw_addr == CBT_MAILBOX_DIR_ADDR;
  wire lo_en   = w_strb[0];
  wire hi_en   = w_strb[1];

  // Merge byte lanes into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic lo, input logic hi);
    merge = {hi ? d[15:8] : old[15:8], lo ? d[7:0] : old[7:0]};
  endfunction

  wire [15:0] next_timing = merge(bit_timing_config, w_data, lo_en, hi_en);
  wire [15:0] dir_merged  = merge(mailbox_direction_config, w_data, lo_en, hi_en);

  // Address and data latches; ready low while one is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready and response registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CBT_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !aw_fire;
      s_axi_wready  <= !w_held && !w_fire;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_tim || wr_dir) ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register update; bit 8 of direction never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_timing_config <= CBT_BIT_TIMING_RST;
      dir_bits          <= {CBT_MAILBOX_DIR_RST[15:9], CBT_MAILBOX_DIR_RST[7:0]};
    end else if (wr_go && wr_tim) begin
      bit_timing_config <= next_timing;
    end else if (wr_go && wr_dir) begin
      dir_bits <= {dir_merged[15:9], dir_merged[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answer the cycle after the arvalid and arready handshake
  wire [15:0] rd_word = (s_axi_araddr == CBT_BIT_TIMING_ADDR) ? bit_timing_config :
                        (s_axi_araddr == CBT_MAILBOX_DIR_ADDR) ? mailbox_direction_config : 16'h0000;
  wire rd_ok = (s_axi_araddr == CBT_BIT_TIMING_ADDR) || (s_axi_araddr == CBT_MAILBOX_DIR_ADDR);
  wire ar_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= CBT_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire && !s_axi_arready;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_ok ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Field decode into quanta and clocks
  wire [1:0] sjw_code   = bit_timing_config[CBT_SJW_LSB +: 2];
  wire [5:0] presc_code = bit_timing_config[CBT_PRESC_LSB +: 6];
  wire       smode      = bit_timing_config[CBT_SMODE_BIT];
  wire [2:0] seg2_code  = bit_timing_config[CBT_SEG2_LSB +: 3];
  wire [3:0] seg1_code  = bit_timing_config[CBT_SEG1_LSB +: 4];
  cbt_timing_t next_timing_dec;
  assign next_timing_dec.sjw_tq    = {1'b0, sjw_code} + 3'd1;
  assign next_timing_dec.tq_clocks = {1'b0, presc_code, 1'b0} + 8'd2;
  assign next_timing_dec.triple    = smode;
  assign next_timing_dec.seg2_tq   = {1'b0, seg2_code} + 4'd1;
  assign next_timing_dec.seg1_tq   = {1'b0, seg1_code} + 5'd1;

  // Direction bits reordered to mailbox numbers
  wire [15:1] next_dir = {dir_bits[7:0], dir_bits[14:8]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing         <= '0;
      mailbox_rx_dir <= '0;
    end else begin
      timing         <= next_timing_dec;
      mailbox_rx_dir <= next_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive line synchroniser
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end

  // Quantum prescaler and phase sequencer; no resync, engine owns that
  logic [7:0]  clk_cnt;
  logic [4:0]  tq_cnt;
  cbt_phase_t  phase;
  logic [2:0]  votes;
  wire tq_end   = clk_cnt == timing.tq_clocks - 8'd1;
  wire seg1_end = phase == CBT_SEG1 && tq_cnt == timing.seg1_tq - 5'd1;
  wire seg2_end = phase == CBT_SEG2 && tq_cnt == {1'b0, timing.seg2_tq} - 5'd1;
  // Sample points: before, at and after the segment-one end quantum
  wire pt_before = phase == CBT_SEG1 && tq_cnt == timing.seg1_tq - 5'd2;
  wire pt_main   = seg1_end;
  wire pt_after  = phase == CBT_SEG2 && tq_cnt == 5'd0;
  // Majority needs the after point, so triple mode reports one quantum later
  wire vote_maj  = (votes[0] & votes[1]) | (votes[0] & rx_sync) | (votes[1] & rx_sync);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cnt       <= 8'h00;
      tq_cnt        <= 5'd0;
      phase         <= CBT_SYNC;
      votes         <= 3'b000;
      sample_strobe <= 1'b0;
      sampled_bit   <= 1'b1;
      bit_start     <= 1'b0;
    end else begin
      sample_strobe <= 1'b0;
      bit_start     <= 1'b0;
      clk_cnt       <= tq_end ? 8'h00 : clk_cnt + 8'd1;
      if (tq_end) begin
        unique case (phase)
          CBT_SYNC: begin
            phase  <= CBT_SEG1;
            tq_cnt <= 5'd0;
          end
          CBT_SEG1: begin
            if (seg1_end) begin
              phase  <= CBT_SEG2;
              tq_cnt <= 5'd0;
            end else begin
              tq_cnt <= tq_cnt + 5'd1;
            end
          end
          CBT_SEG2: begin
            if (seg2_end) begin
              phase     <= CBT_SYNC;
              bit_start <= 1'b1;
            end else begin
              tq_cnt <= tq_cnt + 5'd1;
            end
          end
        endcase
        if (pt_before) votes[0] <= rx_sync;
        if (pt_main) begin
          votes[1] <= rx_sync;
          if (!timing.triple) begin
            sample_strobe <= 1'b1;
            sampled_bit   <= rx_sync;
          end
        end
        if (pt_after && timing.triple) begin
          sample_strobe <= 1'b1;
          sampled_bit   <= vote_maj;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  // Reset is released on the edge that still samples it low, so the
  // decode checks also ask for a sampled high reset before they start.
  sequence s_write_dir;
    wr_go && wr_dir;
  endsequence

  sequence s_write_none;
    wr_go && !wr_tim && !wr_dir;
  endsequence

  sequence s_resp_stall;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  sequence s_read_stall;
    s_axi_rvalid && !s_axi_rready;
  endsequence

  sequence s_read_dir;
    ar_fire && s_axi_araddr == CBT_MAILBOX_DIR_ADDR;
  endsequence

  sequence s_sync_done;
    tq_end && phase == CBT_SYNC;
  endsequence

  // Reserved bit watched on the bus, not on the constant behind it
  a_dir_bit8_one: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_dir |=> s_axi_rdata[CBT_DIR_RSVD_BIT])
    else $error("reserved direction bit not one");
  a_dir_write_map: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_dir ##2 1'b1 |-> mailbox_rx_dir[1] == $past(dir_merged[9], 2))
    else $error("mailbox 1 direction wrong");
  a_dir_low_map: assert property (@(posedge aclk) disable iff (!aresetn)
    mailbox_rx_dir[8] == $past(dir_bits[0]))
    else $error("mailbox 8 direction wrong");
  a_sjw_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && $stable(bit_timing_config) |=> timing.sjw_tq == {1'b0, $past(sjw_code)} + 3'd1)
    else $error("jump width decode wrong");
  a_presc_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && $stable(bit_timing_config) |=> timing.tq_clocks == {1'b0, $past(presc_code), 1'b0} + 8'd2)
    else $error("quantum length wrong");
  a_seg_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && $stable(bit_timing_config) |=> timing.seg1_tq == {1'b0, $past(seg1_code)} + 5'd1
      && timing.seg2_tq == {1'b0, $past(seg2_code)} + 4'd1)
    else $error("segment decode wrong");
  a_single_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    tq_end && pt_main && !timing.triple |=> sample_strobe && sampled_bit == $past(rx_sync))
    else $error("single sample missed");
  a_triple_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    tq_end && pt_after && timing.triple |=> sample_strobe && sampled_bit == $past(vote_maj))
    else $error("triple sample missed");
  a_bit_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    tq_end && seg2_end |=> phase == CBT_SYNC && bit_start)
    else $error("bit did not wrap to sync");

  // Sync part is one quantum, then segment one counts from zero
  a_sync_one_tq: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sync_done |=> phase == CBT_SEG1 && tq_cnt == 5'd0)
    else $error("sync quantum not one quantum");

  // Answers stand until the master takes them; upper read half stays zero
  a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_resp_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_stall |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped before taken");
  a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // A held address or data word blocks its channel until the response
  a_ready_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    !(aw_held && s_axi_awready) && !(w_held && s_axi_wready))
    else $error("ready raised while a word is held");

  // Unmapped writes must leave both registers untouched
  a_unmapped_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_none |=> $stable(bit_timing_config) && $stable(dir_bits))
    else $error("unmapped write changed a register");

endmodule // cbt_regs
`default_nettype wire

// >>> test/cbt_can_node.sv
// Remote CAN node model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module cbt_can_node (
  // Clock
  input  wire logic        aclk,
  // Frame request
  input  wire logic        go,
  input  wire logic [15:0] bits,
  input  wire logic [15:0] bit_len,
  // Line toward the receiver
  output var  logic        can_rx
);
  logic [15:0] sh = 16'h0;
  logic [4:0]  left = 5'h0;
  logic [15:0] cnt = 16'h0;
  // Sixteen bits msb first, each bit_len clocks; its clock is not the receiver's bit grid
  always_ff @(posedge aclk) begin
    if (go && left == 5'h0) begin
      sh <= bits;
      left <= 5'h10;
      cnt <= 16'h0;
    end else if (left != 5'h0) begin
      cnt <= (cnt == bit_len - 16'h1) ? 16'h0 : cnt + 16'h1;
      if (cnt == bit_len - 16'h1) begin
        sh <= sh << 1;
        left <= left - 5'h1;
      end
    end
  end
  // Recessive level between frames
  assign can_rx = (left != 5'h0) ? sh[15] : 1'b1;
endmodule // cbt_can_node
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the CAN timing and direction registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cbt_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, strobe, sbit, bstart, can_rx;
  logic [1:0]  bresp, rresp;
  logic [15:1] dir;
  cbt_timing_t timing;
  logic        go = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic [15:0] bits = 16'h0, blen = 16'h28, v;
  int          bad_count = 0, n_tests = 0, k, m, p0, o0, p1, o1, tq;
  always #25 aclk = ~aclk;
  cbt_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .can_rx(can_rx),
    .mailbox_rx_dir(dir), .timing(timing), .sample_strobe(strobe), .sampled_bit(sbit), .bit_start(bstart));
  cbt_can_node node (.aclk(aclk), .go(go), .bits(bits), .bit_len(blen), .can_rx(can_rx));
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic timeout();
    bad_count++;
    $display("[ERR] %0t wait bound used up", $time);
    final_report();
  endtask
  // Master keeps bready high until the answer; releases each channel as taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (i == 100) timeout();
    chk(bresp, er, "write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (i == 100) timeout();
    chk(rresp, er, "read response");
    chk(rdata, ed, "read data");
  endtask
  // Third bit boundary seen gives one whole bit under the new settings
  task automatic measure(output int per, output int off);
    int i, n;
    off = 0;
    for (n = 0; n < 3; n++) begin
      for (i = 1; i <= 2000; i++) begin
        @(posedge aclk);
        if (strobe === 1'b1) off = i;
        if (bstart === 1'b1) break;
      end
      if (i > 2000) timeout();
    end
    per = i;
  endtask
  task automatic wait_strobe();
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge aclk);
      if (strobe === 1'b1) break;
    end
    if (i == 2000) timeout();
  endtask
  // Legal segment codes only; prescaler limited by pm to keep bits short
  function automatic logic [15:0] rnd_tim(input logic [5:0] pm);
    logic [15:0] r;
    r = 16'($urandom);
    r[13:8] = r[13:8] & pm;
    r[6:4] = 3'(1 + $urandom % 7);
    r[3:0] = 4'(3 + $urandom % 13);
    return r;
  endfunction
  function automatic cbt_timing_t exp_tim(input logic [15:0] r);
    return {3'(r[15:14]) + 3'h1, {1'b0, r[13:8], 1'b0} + 8'h2, r[7], 4'(r[6:4]) + 4'h1, 5'(r[3:0]) + 5'h1};
  endfunction
  function automatic logic [15:1] exp_dir(input logic [15:0] r);
    logic [15:1] e;
    for (int n = 1; n <= 15; n++) e[n] = (n <= 7) ? r[n + 8] : r[n - 8];
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h970c));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Registers are only set up while the engine has no traffic to carry
    axi_rd(CBT_BIT_TIMING_ADDR, CBT_RESP_OKAY, 32'h0000);
    axi_rd(CBT_MAILBOX_DIR_ADDR, CBT_RESP_OKAY, 32'h0100);
    chk(dir, 15'h0, "reset directions");
    $display("test reset done");
    for (k = 0; k < 12; k++) begin
      v = (k == 0) ? 16'h0013 : (k == 1) ? 16'hffff : rnd_tim(6'h3f);
      axi_wr(CBT_BIT_TIMING_ADDR, {16'h0, v}, CBT_RESP_OKAY);
      axi_rd(CBT_BIT_TIMING_ADDR, CBT_RESP_OKAY, {16'h0, v});
      repeat (2) @(posedge aclk);
      chk(timing, exp_tim(v), "timing decode");
    end
    // High byte lane only: the low byte keeps its legal segment codes
    wstrb <= 4'h2;
    axi_wr(CBT_BIT_TIMING_ADDR, {16'h0, ~v}, CBT_RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(CBT_BIT_TIMING_ADDR, CBT_RESP_OKAY, {16'h0, ~v[15:8], v[7:0]});
    $display("test timing fields done");
    for (k = 0; k < 10; k++) begin
      v = (k == 0) ? 16'hfeff : (16'($urandom) | 16'h0100);
      axi_wr(CBT_MAILBOX_DIR_ADDR, {16'h0, v}, CBT_RESP_OKAY);
      axi_rd(CBT_MAILBOX_DIR_ADDR, CBT_RESP_OKAY, {16'h0, v | 16'h0100});
      chk(dir, exp_dir(v), "mailbox directions");
    end
    // Unmapped place refuses and leaves the direction word alone
    axi_wr(8'h08, 32'hffff_ffff, CBT_RESP_SLVERR);
    axi_rd(8'h08, CBT_RESP_SLVERR, 32'h0);
    axi_rd(CBT_MAILBOX_DIR_ADDR, CBT_RESP_OKAY, {16'h0, v | 16'h0100});
    $display("test directions done");
    for (k = 0; k < 5; k++) begin
      v = (k == 0) ? 16'h0013 : (k == 1) ? 16'h037f : rnd_tim(6'h03);
      v[7] = 1'b0;
      tq = 2 * (int'(v[13:8]) + 1);
      axi_wr(CBT_BIT_TIMING_ADDR, {16'h0, v}, CBT_RESP_OKAY);
      measure(p0, o0);
      chk(p0, tq * (3 + int'(v[6:4]) + int'(v[3:0])), "bit length");
      axi_wr(CBT_BIT_TIMING_ADDR, {16'h0, v | 16'h0080}, CBT_RESP_OKAY);
      measure(p1, o1);
      chk(p1, p0, "bit length triple");
      chk(o1 - o0, tq, "triple sample shift");
    end
    $display("test bit sequencer done");
    for (m = 0; m < 2; m++) begin
      axi_wr(CBT_BIT_TIMING_ADDR, (m == 0) ? 32'h0013 : 32'h0093, CBT_RESP_OKAY);
      bits <= 16'h0000;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (60) @(posedge aclk);
      wait_strobe();
      chk(sbit, 1'b0, "dominant sample");
      repeat (700) @(posedge aclk);
      wait_strobe();
      chk(sbit, 1'b1, "recessive sample");
    end
    $display("test sampling done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
